// file: tamper_detect_wake_control_test.sv
// Purpose: self-checking bench for tdwc_top
// Assumes: LONG_CNT shortened so long-match runs stay brief
// Notes:   far side model supplies pins and crystal
`timescale 1ns/100ps
module tamper_detect_wake_control_test;
  import tdwc_pkg::*;
  localparam int LONG_SMALL = 8;
  logic        sys_clk, rstn, io_cfg_wr, io_cfg_enable, io_cfg_pullup, io_cfg_active_high;
  logic        io_cfg_long, tamper_enable, tamper_wake_en, events_clear, osc_on, xosc_running;
  logic        xosc_stable, xosc_is_source, xosc_recover, xosc_good, xosc_active, xosc_failed;
  logic        use_xosc, wake_cfg_wr, wake_pin, rtc_match, low_battery, gpio_wake, reset_pin;
  logic        wake_req, log_rd_valid, is_event;
  logic [1:0]  io_cfg_idx, log_rd_idx;
  logic [3:0]  tamper_pin, tamper_pullup_on, switch_closed;
  logic [4:0]  wake_cfg, wake_cfg_rd, log_rd_src;
  logic [31:0] rtc_time, log_rd_time;
  tdwc_state_e tamper_state;
  int          fails, check_count, n;

  tdwc_top #(.LONG_CNT(LONG_SMALL)) i_tdwc_top (
    .sys_clk, .rstn, .tamper_pin, .tamper_pullup_on, .io_cfg_wr, .io_cfg_idx, .io_cfg_enable,
    .io_cfg_pullup, .io_cfg_active_high, .io_cfg_long, .tamper_enable, .tamper_wake_en,
    .events_clear, .xosc_running, .xosc_stable, .xosc_is_source, .xosc_recover, .xosc_good,
    .xosc_active, .xosc_failed, .use_xosc, .tamper_state, .wake_cfg_wr, .wake_cfg, .wake_cfg_rd,
    .wake_pin, .rtc_match, .low_battery, .gpio_wake, .reset_pin, .wake_req, .rtc_time,
    .log_rd_idx, .log_rd_time, .log_rd_src, .log_rd_valid);
  tdwc_far_side i_tdwc_far_side (.sys_clk, .switch_closed, .osc_on,
    .pullup_on(tamper_pullup_on), .tamper_pin, .xosc_running, .xosc_stable);

  always_comb is_event = (tamper_state == tdwc_state_event);
  always @(posedge sys_clk) rtc_time <= rstn ? rtc_time + 32'h1 : 32'h0;
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask

  // Bounded wait; running out ends the run as a failure
  task automatic wait_hi(ref logic s, output int cnt);
    cnt = 0;
    while (s !== 1'b1) begin
      tick(1);
      cnt++;
      if (cnt > 60) begin
        fails++;
        stop_test();
      end
    end
  endtask

  task automatic cfg_io(input logic [1:0] idx, input logic [3:0] f);
    @(posedge sys_clk);
    io_cfg_wr <= 1'b1;
    io_cfg_idx <= idx;
    {io_cfg_enable, io_cfg_pullup, io_cfg_active_high, io_cfg_long} <= f;
    @(posedge sys_clk);
    io_cfg_wr <= 1'b0;
    tick(1);
  endtask

  task automatic clr();
    @(posedge sys_clk);
    events_clear <= 1'b1;
    @(posedge sys_clk);
    events_clear <= 1'b0;
    tick(1);
  endtask

  task automatic rec();
    @(posedge sys_clk);
    xosc_recover <= 1'b1;
    @(posedge sys_clk);
    xosc_recover <= 1'b0;
    tick(2);
  endtask

  task automatic sw(input int i, input logic v);
    @(posedge sys_clk);
    switch_closed[i] <= v;
  endtask

  task automatic wcfg(input logic [4:0] v);
    @(posedge sys_clk);
    wake_cfg_wr <= 1'b1;
    wake_cfg <= v;
    @(posedge sys_clk);
    wake_cfg_wr <= 1'b0;
    tick(1);
  endtask

  task automatic src(input logic [4:0] v);
    @(posedge sys_clk);
    {reset_pin, gpio_wake, low_battery, rtc_match, wake_pin} <= v;
    tick(1);
  endtask

  task automatic chk_log(input logic v, input logic [4:0] s);
    @(posedge sys_clk);
    log_rd_idx <= 2'h0;
    tick(2);
    chk("log_valid", v, log_rd_valid);
    if (v) chk("log_src", s, log_rd_src);
    if (v) chk("log_age", 1, (rtc_time - log_rd_time) < 32'h20);
  endtask

  task automatic t_short();
    cfg_io(2'h0, 4'hC);
    cfg_io(2'h2, 4'h6);
    chk("pullup", 4'h5, tamper_pullup_on);
    @(posedge sys_clk);
    tamper_enable <= 1'b1;
    tick(2);
    chk("armed", tdwc_state_armed, tamper_state);
    sw(0, 1'b1);
    sw(0, 1'b0);
    tick(8);
    chk("glitch", tdwc_state_armed, tamper_state);
    sw(0, 1'b1);
    wait_hi(is_event, n);
    chk("short_lat", 1, n >= 3 && n <= 5);
    chk_log(1'b1, 5'h01);
    chk_log(1'b1, 5'h01);
    sw(0, 1'b0);
    $display("t_short done");
  endtask

  task automatic t_long();
    clr();
    chk("cleared", tdwc_state_armed, tamper_state);
    chk_log(1'b0, 5'h00);
    sw(1, 1'b1);
    cfg_io(2'h1, 4'hF);
    sw(1, 1'b0);
    tick(LONG_SMALL - 3);
    sw(1, 1'b1);
    tick(3);
    sw(1, 1'b0);
    wait_hi(is_event, n);
    chk("long_lat", 1, n >= LONG_SMALL + 1 && n <= LONG_SMALL + 4);
    chk_log(1'b1, 5'h02);
    sw(1, 1'b1);
    clr();
    $display("t_long done");
  endtask

  task automatic t_disable();
    @(posedge sys_clk);
    tamper_enable <= 1'b0;
    tick(2);
    chk("off", tamper_state_disabled, tamper_state);
    chk("cfg_kept", 4'h7, tamper_pullup_on);
    sw(0, 1'b1);
    tick(10);
    chk("ignored", tamper_state_disabled, tamper_state);
    @(posedge sys_clk);
    tamper_enable <= 1'b1;
    wait_hi(is_event, n);
    chk("reenabled", 1, n <= 8);
    sw(0, 1'b0);
    clr();
    $display("t_disable done");
  endtask

  task automatic t_osc();
    @(posedge sys_clk);
    xosc_is_source <= 1'b1;
    tick(1);
    chk("osc_act", 1, xosc_active);
    chk("osc_good", 1, xosc_good);
    @(posedge sys_clk);
    osc_on <= 1'b0;
    wait_hi(xosc_failed, n);
    chk("osc_inact", 0, xosc_active);
    chk("osc_bad", 0, xosc_good);
    chk("use_int", 0, use_xosc);
    chk("osc_event", tdwc_state_event, tamper_state);
    chk_log(1'b1, 5'h10);
    rec();
    chk("refused", 1, xosc_failed);
    @(posedge sys_clk);
    osc_on <= 1'b1;
    wait_hi(xosc_good, n);
    rec();
    chk("recovered", 0, xosc_failed);
    chk("use_xosc", 1, use_xosc);
    clr();
    $display("t_osc done");
  endtask

  task automatic t_wake();
    for (int b = 0; b < TDWC_WAKE_W; b++) begin
      wcfg(5'h01 << b);
      chk("wake_rd", 5'h01 << b, wake_cfg_rd);
      src(~(5'h01 << b));
      chk("wake_off", 0, wake_req);
      src(5'h01 << b);
      chk("wake_on", 1, wake_req);
    end
    wcfg(5'h15);
    chk("wake_mix", 5'h15, wake_cfg_rd);
    src(5'h00);
    wcfg(5'h00);
    @(posedge sys_clk);
    tamper_wake_en <= 1'b1;
    sw(0, 1'b1);
    wait_hi(is_event, n);
    tick(1);
    chk("tamper_wake", 1, wake_req);
    @(posedge sys_clk);
    tamper_wake_en <= 1'b0;
    tick(2);
    chk("no_tamper_wake", 0, wake_req);
    sw(0, 1'b0);
    clr();
    $display("t_wake done");
  endtask

  initial begin
    rstn = 1'b0;
    {io_cfg_wr, io_cfg_enable, io_cfg_pullup, io_cfg_active_high, io_cfg_long} = '0;
    {tamper_enable, tamper_wake_en, events_clear, xosc_is_source, xosc_recover} = '0;
    {wake_cfg_wr, wake_pin, rtc_match, low_battery, gpio_wake, reset_pin} = '0;
    {io_cfg_idx, log_rd_idx, switch_closed, wake_cfg} = '0;
    osc_on = 1'b1;
    fails = 0;
    check_count = 0;
    tick(16);
    @(posedge sys_clk);
    rstn <= 1'b1;
    tick(8);
    chk("rst_pullup", 4'h0, tamper_pullup_on);
    chk("rst_wake", 5'h00, wake_cfg_rd);
    chk("rst_failed", 0, xosc_failed);
    chk("rst_use", 1, use_xosc);
    chk("rst_state", tamper_state_disabled, tamper_state);
    $display("t_reset done");
    t_short();
    t_long();
    t_disable();
    t_osc();
    t_wake();
    stop_test();
  end

  initial begin
    repeat (100000) @(posedge sys_clk);
    fails++;
    stop_test();
  end
endmodule

// file: tdwc_far_side.sv
// Purpose: far side model: tamper switches to ground and the crystal
// Assumes: a closed switch pulls its pin low
// Notes:   an open pin without pull-up toggles, so it never reads as a clean level
`timescale 1ns/100ps
module tdwc_far_side
  import tdwc_pkg::*;
(
  // Clock
  input  wire logic                       sys_clk,
  // Bench controls
  input  wire logic [TDWC_NUM_INPUTS-1:0] switch_closed,
  input  wire logic                       osc_on,
  // Pad control
  input  wire logic [TDWC_NUM_INPUTS-1:0] pullup_on,
  // Pins
  output logic      [TDWC_NUM_INPUTS-1:0] tamper_pin,
  output logic                            xosc_running,
  output logic                            xosc_stable
);
  logic [2:0] settle = 3'h0;
  logic       float_q = 1'b0;

  always @(posedge sys_clk) begin
    float_q <= ~float_q;
    if (!osc_on) begin
      settle <= 3'h0;
    end else if (settle != 3'h4) begin
      settle <= settle + 3'h1;
    end
  end

  always_comb begin
    for (int i = 0; i < TDWC_NUM_INPUTS; i++) begin
      tamper_pin[i] = switch_closed[i] ? 1'b0 : (pullup_on[i] ? 1'b1 : float_q);
    end
  end

  assign xosc_running = osc_on;
  // Crystal needs some cycles after start before it is stable
  assign xosc_stable  = osc_on && (settle == 3'h4);
endmodule

// file: tdwc_log_mem.sv
// Purpose: tamper log storage, timestamp and source per entry
// Assumes: one write per cycle at most
// Notes:   read data registered; reads never alter contents
`timescale 1ns/100ps
module tdwc_log_mem
  import tdwc_pkg::*;
#(
  parameter int DEPTH = TDWC_LOG_DEPTH,
  parameter int WIDTH = TDWC_RTC_W + TDWC_SRC_W
) (
  // Clock
  input  wire logic                      sys_clk,
  // Write port
  input  wire logic                      wr_en,
  input  wire logic [TDWC_LOG_IDX_W-1:0] wr_idx,
  input  wire logic [WIDTH-1:0]          wr_data,
  // Read port
  input  wire logic [TDWC_LOG_IDX_W-1:0] rd_idx,
  output logic      [WIDTH-1:0]          rd_data
);
  initial begin
    if (DEPTH != (1 << TDWC_LOG_IDX_W))
      $error("tdwc_log_mem: depth must match index width");
  end

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge sys_clk) begin
    if (wr_en)
      mem[wr_idx] <= wr_data;
    rd_data <= mem[rd_idx];
  end
endmodule

// file: tdwc_match.sv
// Purpose: one tamper input: synchroniser and match counter
// Assumes: pin is asynchronous to sys_clk
// Notes:   count restarts whenever the level goes inactive
`timescale 1ns/100ps
module tdwc_match
  import tdwc_pkg::*;
#(
  parameter int SHORT_CNT = TDWC_SHORT_MATCH,
  parameter int LONG_CNT  = TDWC_LONG_MATCH
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rstn,
  // Pin and configuration
  input  wire logic pin,
  input  wire logic enable,
  input  wire logic active_high,
  input  wire logic long_match,
  // Result
  output logic      trigger
);
  initial begin
    if (LONG_CNT >= (1 << TDWC_CNT_W) || SHORT_CNT < 1 || LONG_CNT < SHORT_CNT)
      $error("tdwc_match: match counts out of range");
  end

  logic                  sync1;
  logic                  sync2;
  logic [TDWC_CNT_W-1:0] count;
  wire                   level_active = (sync2 == active_high) && enable;
  wire [TDWC_CNT_W-1:0]  target = long_match ? TDWC_CNT_W'(LONG_CNT) : TDWC_CNT_W'(SHORT_CNT);
  // Saturate at or above target so a mode change mid-count cannot wrap and retrigger
  wire                   reached = (count >= target);

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
    end else begin
      sync1 <= pin;
      sync2 <= sync1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn || !level_active)
      count <= '0;
    else if (!reached)
      count <= count + TDWC_CNT_W'(1);
  end

  // Trigger is a one-cycle pulse when the count first completes
  assign trigger = level_active && (count == target - TDWC_CNT_W'(1));

  property p_match_len;
    @(posedge sys_clk) disable iff (!rstn)
      (trigger && !long_match) |-> level_active && $past(level_active);
  endproperty
  a_match_len: assert property (p_match_len) else $error("trigger without active level");

  property p_restart;
    @(posedge sys_clk) disable iff (!rstn)
      !level_active |=> count == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("count not restarted");
endmodule

// file: tdwc_pkg.sv
// Purpose: shared constants for the tamper detect and wake control block
// Assumes: one clock (the hibernation clock) drives the whole block
// Notes:   match counts are in hibernation clock cycles
package tdwc_pkg;
  localparam int TDWC_NUM_INPUTS   = 4;
  localparam int TDWC_SHORT_MATCH  = 2;
  localparam int TDWC_LONG_MATCH   = 3071;
  localparam int TDWC_CNT_W        = 12;
  localparam int TDWC_RTC_W        = 32;
  localparam int TDWC_LOG_DEPTH    = 4;
  localparam int TDWC_LOG_IDX_W    = 2;
  // Log source field: bit per tamper input, then oscillator failure
  localparam int TDWC_SRC_W        = 5;
  localparam int TDWC_SRC_XOSC_BIT = 4;
  // Wake enable field positions
  localparam int TDWC_WAKE_W       = 5;
  localparam int TDWC_WAKE_PIN_BIT = 0;
  localparam int TDWC_WAKE_RTC_BIT = 1;
  localparam int TDWC_WAKE_BAT_BIT = 2;
  localparam int TDWC_WAKE_GPIO_BIT = 3;
  localparam int TDWC_WAKE_RST_BIT = 4;
  localparam logic [4:0] TDWC_WAKE_RESET_VAL = 5'h00;
  localparam logic [3:0] TDWC_CFG_RESET_VAL  = 4'h0;

  typedef enum logic [1:0] {
    tamper_state_disabled,
    tdwc_state_armed,
    tdwc_state_event
  } tdwc_state_e;
endpackage

// file: tdwc_top.sv
// Purpose: tamper detection, oscillator health and wake enable control
// Assumes: sys_clk is the hibernation clock; all config bits are plain ports
// Notes:   log valid bits, not memory contents, are cleared by an event clear
`timescale 1ns/100ps
// Overview of operation
// - four tamper inputs, each independently enabled
// - short match triggers after two cycles
// - long match triggers after 3071 cycles
// - per-input weak pull-up pad control
// - per-input active high or low
// - status: disabled, armed, or event seen
// - report oscillator active or inactive
// - failed once oscillator goes valid to invalid while it is the clock source
// - oscillator good: running and stable
// - recovery clears failure, resumes external oscillator
// - five independent wake enables
// - wake enables read back exactly
// - tamper wake is separate enable
// - event clear resets state and log
// - four log entries, timestamp and source
module tdwc_top
  import tdwc_pkg::*;
#(
  parameter int LONG_CNT = TDWC_LONG_MATCH
) (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rstn,
  // Tamper pins and pad control
  input  wire logic [TDWC_NUM_INPUTS-1:0] tamper_pin,
  output logic      [TDWC_NUM_INPUTS-1:0] tamper_pullup_on,
  // Per-input configuration strobe
  input  wire logic                       io_cfg_wr,
  input  wire logic [TDWC_LOG_IDX_W-1:0]  io_cfg_idx,
  input  wire logic                       io_cfg_enable,
  input  wire logic                       io_cfg_pullup,
  input  wire logic                       io_cfg_active_high,
  input  wire logic                       io_cfg_long,
  // Global tamper control
  input  wire logic                       tamper_enable,
  input  wire logic                       tamper_wake_en,
  input  wire logic                       events_clear,
  // Oscillator
  input  wire logic                       xosc_running,
  input  wire logic                       xosc_stable,
  input  wire logic                       xosc_is_source,
  input  wire logic                       xosc_recover,
  output logic                            xosc_good,
  output logic                            xosc_active,
  output logic                            xosc_failed,
  output logic                            use_xosc,
  // Tamper status
  output tdwc_state_e                     tamper_state,
  // Wake configuration and sources
  input  wire logic                       wake_cfg_wr,
  input  wire logic [TDWC_WAKE_W-1:0]     wake_cfg,
  output logic      [TDWC_WAKE_W-1:0]     wake_cfg_rd,
  input  wire logic                       wake_pin,
  input  wire logic                       rtc_match,
  input  wire logic                       low_battery,
  input  wire logic                       gpio_wake,
  input  wire logic                       reset_pin,
  output logic                            wake_req,
  // Log access
  input  wire logic [TDWC_RTC_W-1:0]      rtc_time,
  input  wire logic [TDWC_LOG_IDX_W-1:0]  log_rd_idx,
  output logic      [TDWC_RTC_W-1:0]      log_rd_time,
  output logic      [TDWC_SRC_W-1:0]      log_rd_src,
  output logic                            log_rd_valid
);
  initial begin
    if (LONG_CNT < TDWC_SHORT_MATCH || LONG_CNT >= (1 << TDWC_CNT_W))
      $error("tdwc_top: LONG_CNT out of range");
  end

  localparam int LOG_W = TDWC_RTC_W + TDWC_SRC_W;

  // Configuration storage
  logic [TDWC_NUM_INPUTS-1:0] in_en;
  logic [TDWC_NUM_INPUTS-1:0] in_high;
  logic [TDWC_NUM_INPUTS-1:0] in_long;
  logic [TDWC_WAKE_W-1:0]     wake_en;
  logic                       tamp_wake;
  // Oscillator synchronisers
  logic [1:0]                 run_sync;
  logic [1:0]                 stab_sync;
  logic                       osc_ok_q;
  // Event and log state
  logic                       event_seen;
  logic [TDWC_LOG_DEPTH-1:0]  log_valid;
  logic [TDWC_LOG_IDX_W-1:0]  log_wr_ptr;
  logic                       log_full;
  logic [TDWC_NUM_INPUTS-1:0] trig;
  logic [TDWC_RTC_W-1:0]      rtc_q;
  logic [LOG_W-1:0]           log_rd_word;
  logic [TDWC_LOG_IDX_W-1:0]  log_idx_q;

  // Oscillator health after synchronising its status lines
  wire osc_run   = run_sync[1];
  wire osc_ok    = run_sync[1] && stab_sync[1];
  wire osc_fall  = osc_ok_q && !osc_ok && xosc_is_source;
  wire [TDWC_SRC_W-1:0] event_src = {osc_fall, trig};
  wire any_event = tamper_enable && (|event_src);
  wire log_write = any_event && !log_full;
  // recovery accepted only when oscillator good and in use
  wire recover_ok = xosc_recover && osc_ok && xosc_is_source;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      in_en            <= TDWC_CFG_RESET_VAL;
      in_high          <= TDWC_CFG_RESET_VAL;
      in_long          <= TDWC_CFG_RESET_VAL;
      tamper_pullup_on <= TDWC_CFG_RESET_VAL;
    end else if (io_cfg_wr) begin
      in_en[io_cfg_idx]            <= io_cfg_enable;
      in_high[io_cfg_idx]          <= io_cfg_active_high;
      in_long[io_cfg_idx]          <= io_cfg_long;
      tamper_pullup_on[io_cfg_idx] <= io_cfg_pullup;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      wake_en   <= TDWC_WAKE_RESET_VAL;
      tamp_wake <= 1'b0;
    end else begin
      if (wake_cfg_wr)
        wake_en <= wake_cfg;
      tamp_wake <= tamper_wake_en;
    end
  end

  assign wake_cfg_rd = wake_en;

  wire wake_on_low_battery = wake_en[TDWC_WAKE_BAT_BIT];
  assign wake_req = (wake_en[TDWC_WAKE_PIN_BIT] && wake_pin)
                 || (wake_en[TDWC_WAKE_RTC_BIT] && rtc_match)
                 || (wake_on_low_battery && low_battery)
                 || (wake_en[TDWC_WAKE_GPIO_BIT] && gpio_wake)
                 || (wake_en[TDWC_WAKE_RST_BIT] && reset_pin)
                 || (tamp_wake && event_seen);

  genvar gi;
  generate
    for (gi = 0; gi < TDWC_NUM_INPUTS; gi++) begin : g_in
      tdwc_match #(
        .SHORT_CNT (TDWC_SHORT_MATCH),
        .LONG_CNT  (LONG_CNT)
      ) u_match (
        .sys_clk     (sys_clk),
        .rstn        (rstn),
        .pin         (tamper_pin[gi]),
        .enable      (in_en[gi] && tamper_enable),
        .active_high (in_high[gi]),
        .long_match  (in_long[gi]),
        .trigger     (trig[gi])
      );
    end
  endgenerate

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      run_sync  <= 2'h0;
      stab_sync <= 2'h0;
      osc_ok_q  <= 1'b0;
    end else begin
      run_sync  <= {run_sync[0], xosc_running};
      stab_sync <= {stab_sync[0], xosc_stable};
      osc_ok_q  <= osc_ok;
    end
  end

  assign xosc_good   = osc_ok;
  assign xosc_active = osc_run;

  // failure flag, a new failure wins over recovery
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      xosc_failed <= 1'b0;
      use_xosc    <= 1'b1;
    end else if (osc_fall) begin
      xosc_failed <= 1'b1;
      use_xosc    <= 1'b0;
    end else if (xosc_failed && recover_ok) begin
      xosc_failed <= 1'b0;
      use_xosc    <= 1'b1;
    end
  end

  // event flag; a new event wins over the clear
  always_ff @(posedge sys_clk) begin
    if (!rstn)
      event_seen <= 1'b0;
    else if (any_event)
      event_seen <= 1'b1;
    else if (events_clear)
      event_seen <= 1'b0;
  end

  assign tamper_state = !tamper_enable ? tamper_state_disabled
                      : event_seen ? tdwc_state_event : tdwc_state_armed;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      log_valid  <= '0;
      log_wr_ptr <= '0;
      log_full   <= 1'b0;
    end else if (log_write) begin
      log_valid[log_wr_ptr] <= 1'b1;
      log_wr_ptr <= log_wr_ptr + TDWC_LOG_IDX_W'(1);
      log_full   <= (log_wr_ptr == TDWC_LOG_IDX_W'(TDWC_LOG_DEPTH - 1));
    end else if (events_clear) begin
      log_valid  <= '0;
      log_wr_ptr <= '0;
      log_full   <= 1'b0;
    end
  end

  // Timestamp registered so the log write sees a stable value
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rtc_q     <= '0;
      log_idx_q <= '0;
    end else begin
      rtc_q     <= rtc_time;
      log_idx_q <= log_rd_idx;
    end
  end

  // log storage, reads do not consume
  tdwc_log_mem #(
    .DEPTH (TDWC_LOG_DEPTH),
    .WIDTH (LOG_W)
  ) u_log (
    .sys_clk (sys_clk),
    .wr_en   (log_write),
    .wr_idx  (log_wr_ptr),
    .wr_data ({rtc_q, event_src}),
    .rd_idx  (log_rd_idx),
    .rd_data (log_rd_word)
  );

  assign log_rd_time  = log_rd_word[LOG_W-1:TDWC_SRC_W];
  assign log_rd_src   = log_rd_word[TDWC_SRC_W-1:0];
  assign log_rd_valid = log_valid[log_idx_q];

  property p_clear_log;
    @(posedge sys_clk) disable iff (!rstn)
      (events_clear && !any_event) |=> (log_valid == '0) && !event_seen;
  endproperty
  a_clear_log: assert property (p_clear_log) else $error("clear left log or event");

  property p_event_state;
    @(posedge sys_clk) disable iff (!rstn)
      (any_event && tamper_enable) ##1 tamper_enable |-> tamper_state == tdwc_state_event;
  endproperty
  a_event_state: assert property (p_event_state) else $error("event not reported");

  property p_disabled;
    @(posedge sys_clk) disable iff (!rstn)
      !tamper_enable |-> tamper_state == tamper_state_disabled;
  endproperty
  a_disabled: assert property (p_disabled) else $error("disabled not shown");

  property p_fail;
    @(posedge sys_clk) disable iff (!rstn)
      osc_fall |=> xosc_failed && !use_xosc;
  endproperty
  a_fail: assert property (p_fail) else $error("failure not flagged");

  property p_recover;
    @(posedge sys_clk) disable iff (!rstn)
      (xosc_failed && recover_ok && !osc_fall) |=> !xosc_failed && use_xosc;
  endproperty
  a_recover: assert property (p_recover) else $error("recovery ignored");

  property p_good;
    @(posedge sys_clk) disable iff (!rstn)
      xosc_good |-> $past(xosc_running, 2) && $past(xosc_stable, 2);
  endproperty
  a_good: assert property (p_good) else $error("good without stable osc");

  property p_wake_rd;
    @(posedge sys_clk) disable iff (!rstn)
      wake_cfg_wr |=> wake_cfg_rd == $past(wake_cfg);
  endproperty
  a_wake_rd: assert property (p_wake_rd) else $error("wake readback wrong");

  property p_wake_rtc;
    @(posedge sys_clk) disable iff (!rstn)
      (wake_en[TDWC_WAKE_RTC_BIT] && rtc_match) |-> wake_req;
  endproperty
  a_wake_rtc: assert property (p_wake_rtc) else $error("rtc wake missing");

  property p_log_valid;
    @(posedge sys_clk) disable iff (!rstn)
      log_write |=> log_valid[$past(log_wr_ptr)];
  endproperty
  a_log_valid: assert property (p_log_valid) else $error("log entry not valid");
endmodule
